/* File: hw/psv_pkg.sv */
// constants and encodings for the program sequencer with interrupt vectors
package psv_pkg;
    // program counter and pipeline timing
    localparam int          PC_W            = 12;
    localparam int          PM_WORDS        = 4096;
    localparam int          INSTR_W         = 16;
    localparam int          CLKS_PER_ICYC   = 4;
    localparam logic [1:0]  PH_FETCH        = 2'h0;
    localparam logic [1:0]  PH_LAST         = 2'h3;
    localparam logic [11:0] PC_RESET        = 12'h000;
    localparam int          STACK_DEPTH_DEF = 8;

    // interrupt sources, lowest index has the lowest vector and wins
    localparam int          NUM_SRC         = 6;
    localparam int          SRC_EXT_ADC     = 0;
    localparam int          SRC_EV0         = 1;
    localparam int          SRC_EV1         = 2;
    localparam int          SRC_UART        = 3;
    localparam int          SRC_TWI         = 4;
    localparam int          SRC_EV2         = 5;
    localparam logic [11:0] VEC_EXT_ADC     = 12'h004;
    localparam logic [11:0] VEC_EV0         = 12'h008;
    localparam logic [11:0] VEC_EV1         = 12'h00c;
    localparam logic [11:0] VEC_UART        = 12'h010;
    localparam logic [11:0] VEC_TWI         = 12'h014;
    localparam logic [11:0] VEC_EV2         = 12'h018;

    // execute-stage answer from the core, sampled in the last phase
    localparam logic [2:0]  XF_NONE         = 3'h0;
    localparam logic [2:0]  XF_SKIP         = 3'h1;
    localparam logic [2:0]  XF_JUMP         = 3'h2;
    localparam logic [2:0]  XF_CALL         = 3'h3;
    localparam logic [2:0]  XF_RET          = 3'h4;
    localparam logic [2:0]  XF_RETI         = 3'h5;
    localparam logic [2:0]  XF_PCL          = 3'h6;

    // register indices; byte address is four times the index
    localparam int          AXI_ADDR_W      = 8;
    localparam logic [5:0]  IDX_CTRL        = 6'h00;
    localparam logic [5:0]  IDX_PC          = 6'h01;
    localparam logic [5:0]  IDX_INT_STS     = 6'h02;
    localparam logic [5:0]  IDX_INT_MASK    = 6'h03;
    localparam logic [5:0]  IDX_PCL         = 6'h06;
    localparam int          CTRL_GIE_BIT    = 0;
    localparam int          CTRL_V4ADC_BIT  = 1;
    localparam logic [1:0]  CTRL_RESET      = 2'h0;
    localparam logic [5:0]  MASK_RESET      = 6'h00;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

/* File: hw/psv_stack.sv */
// return address stack; a push when full drops the oldest entry
`timescale 1ns/1ps
`default_nettype none
module psv_stack #(
    parameter int DEPTH = psv_pkg::STACK_DEPTH_DEF
) (
    // clock and control
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    input  wire logic                    clk_en,
    // push and pop
    input  wire logic                    push,
    input  wire logic                    pop,
    input  wire logic [psv_pkg::PC_W-1:0] push_addr,
    // state
    output logic      [psv_pkg::PC_W-1:0] top_addr,
    output logic                         full
);
    import psv_pkg::*;
    localparam int PTR_W = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("stack depth must be a power of two, at least 2");
    end

    logic [PC_W-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wp_r;
    logic [PTR_W:0]   cnt_r;
    wire  [PTR_W-1:0] rp = wp_r - {{(PTR_W-1){1'b0}}, 1'b1};

    assign top_addr = mem[rp];
    assign full     = (cnt_r == (PTR_W+1)'(DEPTH));

    // circular write pointer keeps only the newest entries on overflow
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wp_r  <= '0;
            cnt_r <= '0;
        end else if (clk_en) begin
            if (push) begin
                mem[wp_r] <= push_addr;
                wp_r      <= wp_r + {{(PTR_W-1){1'b0}}, 1'b1};
                if (!full)
                    cnt_r <= cnt_r + {{PTR_W{1'b0}}, 1'b1};
            end else if (pop && cnt_r != '0) begin
                wp_r  <= rp;
                cnt_r <= cnt_r - {{PTR_W{1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

/* File: hw/psv_sequencer.sv */
// program sequencer: pc, two-stage pipeline, interrupt vectoring, axi4-lite registers
// Overview of operation
// - one instruction cycle is four system clocks, split into phases.
// - fetch of next word overlaps execution of current one, one cycle each.
// - any pc-altering instruction takes two cycles via an inserted dummy cycle.
// - program counter is 12 bits, covering 4096 program words.
// - pc increments by one after each program word fetch.
// - met skip discards the prefetched word, runs a dummy, continues at pc+2.
// - low pc byte readable/writable; writing jumps within current 256-word page.
// - jumps/calls load 12 bits from instruction, returns from the stack.
// - reset clears the pc so execution starts at address 000h.
// - vector 004h serves pin or converter interrupt by option, if enabled, stack free.
// - enabled event counter zero overflow vectors to 008h when stack not full.
// - enabled event counter one overflow vectors to 00ch when stack not full.
// - enabled uart completion interrupt vectors to 010h when stack not full.
// - enabled two-wire bus interrupt vectors to 014h when stack not full.
// - enabled event counter two overflow vectors to 018h when stack not full.
// - stack full keeps request latched, acknowledged after a return frees a level.
`timescale 1ns/1ps
`default_nettype none
module psv_sequencer #(
    parameter int STACK_DEPTH = psv_pkg::STACK_DEPTH_DEF
) (
    // clock, reset, enable
    input  wire logic                              core_clk,
    input  wire logic                              rst_n,
    input  wire logic                              clk_en,
    // program memory
    output logic      [psv_pkg::PC_W-1:0]          pm_addr,
    output logic                                   pm_rd,
    input  wire logic [psv_pkg::INSTR_W-1:0]       pm_data,
    // execute stage towards the core
    output logic      [psv_pkg::INSTR_W-1:0]       exec_instr,
    output logic      [psv_pkg::PC_W-1:0]          exec_addr,
    output logic                                   exec_valid,
    output logic                                   exec_last_phase,
    input  wire logic [2:0]                        xfer_kind,
    input  wire logic [psv_pkg::PC_W-1:0]          xfer_target,
    // interrupt sources
    input  wire logic                              ext_int_pin_n,
    input  wire logic                              adc_done_req,
    input  wire logic                              ev0_ovf_req,
    input  wire logic                              ev1_ovf_req,
    input  wire logic                              uart_req,
    input  wire logic                              twi_req,
    input  wire logic                              ev2_ovf_req,
    output logic                                   irq,
    output logic                                   stack_full,
    // axi4-lite slave
    input  wire logic [psv_pkg::AXI_ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                              s_axi_awvalid,
    output logic                                   s_axi_awready,
    input  wire logic [31:0]                       s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    input  wire logic                              s_axi_wvalid,
    output logic                                   s_axi_wready,
    output logic      [1:0]                        s_axi_bresp,
    output logic                                   s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    input  wire logic [psv_pkg::AXI_ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                              s_axi_arvalid,
    output logic                                   s_axi_arready,
    output logic      [31:0]                       s_axi_rdata,
    output logic      [1:0]                        s_axi_rresp,
    output logic                                   s_axi_rvalid,
    input  wire logic                              s_axi_rready
);
    import psv_pkg::*;

    initial begin
        if (PC_W != $clog2(PM_WORDS) || CLKS_PER_ICYC != 4)
            $error("pc width must address the program memory in four-clock cycles");
    end

    localparam logic [11:0] VEC_TAB [NUM_SRC] = '{VEC_EXT_ADC, VEC_EV0, VEC_EV1, VEC_UART, VEC_TWI, VEC_EV2};

    // pipeline state
    logic [1:0]         phase_r;
    logic [PC_W-1:0]    pc_r;
    logic [PC_W-1:0]    pc_nxt;
    logic [PC_W-1:0]    fetch_addr_r;
    logic [PC_W-1:0]    pm_addr_r;
    logic               pm_rd_r;
    logic [INSTR_W-1:0] exec_instr_r;
    logic [PC_W-1:0]    exec_addr_r;
    logic               exec_valid_r;
    // registers
    logic [1:0]         ctrl_r;
    logic [NUM_SRC-1:0] sts_r;
    logic [NUM_SRC-1:0] mask_r;
    logic [7:0]         pcl_wr_r;
    logic               pcl_pend_r;
    // pin synchroniser
    logic               ext_s1_r;
    logic               ext_s2_r;
    logic               ext_s3_r;
    // axi state
    logic               aw_ok_r;
    logic               w_ok_r;
    logic [5:0]         aw_idx_r;
    logic [7:0]         wdata_r;
    logic               wstrb0_r;
    logic               bvalid_r;
    logic [1:0]         bresp_r;
    logic               rvalid_r;
    logic [31:0]        rdata_r;
    logic [1:0]         rresp_r;

    // phase decoding
    wire fetch_ph = (phase_r == PH_FETCH);
    wire last_ph  = (phase_r == PH_LAST);

    // execute-stage decode
    wire xv       = last_ph && exec_valid_r;
    wire do_jump  = xv && (xfer_kind == XF_JUMP || xfer_kind == XF_CALL);
    wire do_call  = xv && (xfer_kind == XF_CALL);
    wire do_ret   = xv && (xfer_kind == XF_RET || xfer_kind == XF_RETI);
    wire do_reti  = xv && (xfer_kind == XF_RETI);
    wire do_skip  = xv && (xfer_kind == XF_SKIP);
    wire do_pcl   = xv && (xfer_kind == XF_PCL);
    wire core_xf  = do_jump || do_ret || do_skip || do_pcl;
    wire sw_pcl   = last_ph && !core_xf && pcl_pend_r;

    // interrupt arbitration
    wire [NUM_SRC-1:0] int_pend  = sts_r & mask_r;
    wire               gie       = ctrl_r[CTRL_GIE_BIT];
    wire               irq_take  = last_ph && !core_xf && !pcl_pend_r && gie
                                   && (|int_pend) && !stack_full;
    wire               redirect  = core_xf || sw_pcl || irq_take;
    logic [NUM_SRC-1:0] ack_onehot;
    logic [PC_W-1:0]    vec_sel;

    always_comb begin
        ack_onehot = '0;
        vec_sel    = VEC_TAB[0];
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (int_pend[i]) begin
                ack_onehot = '0;
                ack_onehot[i] = irq_take;
                vec_sel       = VEC_TAB[i];
            end
        end
    end

    // stack
    logic [PC_W-1:0] stack_top;
    psv_stack #(
        .DEPTH     (STACK_DEPTH)
    ) u_stack (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .push      (do_call || irq_take),
        .pop       (do_ret),
        .push_addr (fetch_addr_r),
        .top_addr  (stack_top),
        .full      (stack_full)
    );

    // next pc; skip leaves pc alone since it already points past the discarded word
    always_comb begin
        pc_nxt = pc_r;
        if (fetch_ph)
            pc_nxt = pc_r + 12'h001;
        else if (do_jump)
            pc_nxt = xfer_target;
        else if (do_ret)
            pc_nxt = stack_top;
        else if (do_pcl)
            pc_nxt = {pc_r[PC_W-1:8], xfer_target[7:0]};
        else if (sw_pcl)
            pc_nxt = {pc_r[PC_W-1:8], pcl_wr_r};
        else if (irq_take)
            pc_nxt = vec_sel;
    end

    // phase counter and fetch stage
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            phase_r      <= PH_FETCH;
            pc_r         <= PC_RESET;
            fetch_addr_r <= PC_RESET;
            pm_addr_r    <= PC_RESET;
            pm_rd_r      <= 1'b0;
        end else if (clk_en) begin
            phase_r <= phase_r + 2'h1;
            pc_r    <= pc_nxt;
            pm_rd_r <= fetch_ph;
            if (fetch_ph) begin
                pm_addr_r    <= pc_r;
                fetch_addr_r <= pc_r;
            end
        end
    end

    // execute stage; a redirect turns the prefetched word into a dummy cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            exec_instr_r <= '0;
            exec_addr_r  <= PC_RESET;
            exec_valid_r <= 1'b0;
        end else if (clk_en && last_ph) begin
            exec_instr_r <= pm_data;
            exec_addr_r  <= fetch_addr_r;
            exec_valid_r <= !redirect;
        end
    end

    // external pin synchroniser and falling-edge detect
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ext_s1_r <= 1'b1;
            ext_s2_r <= 1'b1;
            ext_s3_r <= 1'b1;
        end else if (clk_en) begin
            ext_s1_r <= ext_int_pin_n;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    wire ext_fall = ext_s3_r && !ext_s2_r;
    wire [NUM_SRC-1:0] src_req;
    assign src_req[SRC_EXT_ADC] = ctrl_r[CTRL_V4ADC_BIT] ? adc_done_req : ext_fall;
    assign src_req[SRC_EV0]     = ev0_ovf_req;
    assign src_req[SRC_EV1]     = ev1_ovf_req;
    assign src_req[SRC_UART]    = uart_req;
    assign src_req[SRC_TWI]     = twi_req;
    assign src_req[SRC_EV2]     = ev2_ovf_req;

    // axi decode
    wire       do_wr    = aw_ok_r && w_ok_r && !bvalid_r;
    wire       wr_en    = do_wr && wstrb0_r;
    wire       wr_ctrl  = wr_en && (aw_idx_r == IDX_CTRL);
    wire       wr_sts   = wr_en && (aw_idx_r == IDX_INT_STS);
    wire       wr_mask  = wr_en && (aw_idx_r == IDX_INT_MASK);
    wire       wr_pcl   = wr_en && (aw_idx_r == IDX_PCL);
    wire       wr_map   = (aw_idx_r == IDX_CTRL) || (aw_idx_r == IDX_PC) || (aw_idx_r == IDX_INT_STS)
                          || (aw_idx_r == IDX_INT_MASK) || (aw_idx_r == IDX_PCL);
    wire [5:0] ar_idx   = s_axi_araddr[AXI_ADDR_W-1:2];
    wire       ar_hs    = s_axi_arvalid && !rvalid_r;
    wire       ar_map   = (ar_idx == IDX_CTRL) || (ar_idx == IDX_PC) || (ar_idx == IDX_INT_STS)
                          || (ar_idx == IDX_INT_MASK) || (ar_idx == IDX_PCL);
    wire [31:0] rd_mux  = (ar_idx == IDX_CTRL)     ? {30'h0, ctrl_r} :
                          (ar_idx == IDX_PC)       ? {20'h0, pc_r} :
                          (ar_idx == IDX_INT_STS)  ? {26'h0, sts_r} :
                          (ar_idx == IDX_INT_MASK) ? {26'h0, mask_r} :
                          (ar_idx == IDX_PCL)      ? {24'h0, pc_r[7:0]} : 32'h0;

    // sticky status: a new request wins over a clear in the same cycle
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_sts
            always_ff @(posedge core_clk) begin
                if (!rst_n)
                    sts_r[g] <= 1'b0;
                else if (clk_en) begin
                    if (src_req[g])
                        sts_r[g] <= 1'b1;
                    else if ((wr_sts && wdata_r[g]) || ack_onehot[g])
                        sts_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // control, mask and pending short jump from software
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_r     <= CTRL_RESET;
            mask_r     <= MASK_RESET;
            pcl_wr_r   <= 8'h00;
            pcl_pend_r <= 1'b0;
        end else if (clk_en) begin
            if (wr_ctrl)
                ctrl_r <= wdata_r[1:0];
            else if (irq_take)
                ctrl_r[CTRL_GIE_BIT] <= 1'b0;
            else if (do_reti)
                ctrl_r[CTRL_GIE_BIT] <= 1'b1;
            if (wr_mask)
                mask_r <= wdata_r[NUM_SRC-1:0];
            if (wr_pcl) begin
                pcl_wr_r   <= wdata_r;
                pcl_pend_r <= 1'b1;
            end else if (sw_pcl)
                pcl_pend_r <= 1'b0;
        end
    end

    // axi write channel
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            aw_ok_r  <= 1'b0;
            w_ok_r   <= 1'b0;
            aw_idx_r <= 6'h00;
            wdata_r  <= 8'h00;
            wstrb0_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok_r  <= 1'b1;
                aw_idx_r <= s_axi_awaddr[AXI_ADDR_W-1:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok_r   <= 1'b1;
                wdata_r  <= s_axi_wdata[7:0];
                wstrb0_r <= s_axi_wstrb[0];
            end
            if (do_wr) begin
                aw_ok_r  <= 1'b0;
                w_ok_r   <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready)
                bvalid_r <= 1'b0;
        end
    end

    // axi read channel
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0;
            rresp_r  <= RESP_OKAY;
        end else if (clk_en) begin
            if (ar_hs) begin
                rvalid_r <= 1'b1;
                rdata_r  <= rd_mux;
                rresp_r  <= ar_map ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_r && s_axi_rready)
                rvalid_r <= 1'b0;
        end
    end

    // outputs
    assign pm_addr         = pm_addr_r;
    assign pm_rd           = pm_rd_r;
    assign exec_instr      = exec_instr_r;
    assign exec_addr       = exec_addr_r;
    assign exec_valid      = exec_valid_r;
    assign exec_last_phase = last_ph;
    assign irq             = |int_pend;
    assign s_axi_awready   = !aw_ok_r && !bvalid_r;
    assign s_axi_wready    = !w_ok_r && !bvalid_r;
    assign s_axi_bvalid    = bvalid_r;
    assign s_axi_bresp     = bresp_r;
    assign s_axi_arready   = !rvalid_r;
    assign s_axi_rvalid    = rvalid_r;
    assign s_axi_rdata     = rdata_r;
    assign s_axi_rresp     = rresp_r;
endmodule
`default_nettype wire

/* File: dv/psv_pmem_model.sv */
// program memory model: registered read, word tagged with its address
`timescale 1ns/1ps
`default_nettype none
module psv_pmem_model (
    input  wire logic        core_clk,
    input  wire logic        pm_rd,
    input  wire logic [11:0] pm_addr,
    output logic      [15:0] pm_data
);
    // output register holds the word until the next read, like a synchronous rom
    always_ff @(posedge core_clk) begin
        if (pm_rd) begin
            pm_data <= {4'ha, pm_addr};
        end
    end
endmodule
`default_nettype wire

/* File: dv/psv_checker.sv */
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module psv_checker (
    input wire logic        core_clk, rst_n, pm_rd, exec_valid, exec_last_phase, irq, ext_int_pin_n,
    input wire logic        adc_done_req, ev0_ovf_req, ev1_ovf_req, uart_req, twi_req, ev2_ovf_req,
    input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
    input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire logic [2:0]  xfer_kind,
    input wire logic [11:0] pm_addr, exec_addr, xfer_target
);
    import psv_pkg::*;
    wire w_take = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
    // pin counts as a cause while low; its edge reaches status three clocks late
    wire cause = adc_done_req | ev0_ovf_req | ev1_ovf_req | uart_req | twi_req | ev2_ovf_req | w_take | !ext_int_pin_n;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence jump_seen; exec_last_phase && exec_valid && xfer_kind == XF_JUMP; endsequence
    sequence skip_seen; exec_last_phase && exec_valid && xfer_kind == XF_SKIP; endsequence
    sequence plain_step; exec_last_phase ##1 exec_valid; endsequence
    phase_cycle_a: assert property (exec_last_phase |=> !exec_last_phase [*3] ##1 exec_last_phase)
        else $error("instruction cycle not four clocks");
    fetch_pulse_a: assert property (exec_last_phase |-> ##2 pm_rd)
        else $error("no fetch strobe after boundary");
    pc_step_a: assert property (plain_step |=> pm_addr == $past(pm_addr, 2) + 12'h001)
        else $error("fetch address did not step by one");
    jump_load_a: assert property (jump_seen |=> !exec_valid ##1 pm_addr == $past(xfer_target, 2))
        else $error("jump target or dummy cycle wrong");
    skip_load_a: assert property (skip_seen |=> !exec_valid ##1 pm_addr == $past(exec_addr, 2) + 12'h002)
        else $error("skip did not continue at plus two");
    reset_clear_a: assert property (disable iff (1'b0) !rst_n |=> pm_addr == PC_RESET && !exec_valid && !irq)
        else $error("reset did not clear sequencer");
    irq_cause_a: assert property ($rose(irq) |-> $past(cause) || $past(cause, 2) || $past(cause, 3))
        else $error("interrupt rose without a request");
    irq_drop_a: assert property ($fell(irq) |-> $past(w_take) || $past(w_take, 2) || $past(exec_last_phase))
        else $error("interrupt fell off a boundary");
    write_answer_a: assert property (w_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response late");
endmodule
`default_nettype wire

/* File: dv/program_sequencer_vectors_bench.sv */
// self-checking bench for the program sequencer
`timescale 1ns/1ps
`default_nettype none
module program_sequencer_vectors_bench;
    import psv_pkg::*;
    logic        core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, ext_int_pin_n = 1'b1;
    logic        adc_done_req = 1'b0, ev0_ovf_req = 1'b0, ev1_ovf_req = 1'b0;
    logic        uart_req = 1'b0, twi_req = 1'b0, ev2_ovf_req = 1'b0;
    logic [2:0]  xfer_kind = XF_NONE;
    logic [11:0] xfer_target = 12'h000, pm_addr, exec_addr, ret_e, last;
    logic [15:0] pm_data, exec_instr;
    logic        pm_rd, exec_valid, exec_last_phase, irq, stack_full;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [14:0] rows [7] = '{{XF_JUMP, 12'h3f0}, {XF_CALL, 12'h123}, {XF_PCL, 12'h0a5},
                              {XF_SKIP, 12'h000}, {XF_RET, 12'h000}, {XF_JUMP, 12'hffe}, {XF_SKIP, 12'h000}};
    int          mismatches = 0, checks = 0;
    always #50 core_clk = ~core_clk;
    psv_sequencer #(.STACK_DEPTH(8)) dut (.*);
    psv_pmem_model pmem (.*);
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task summarize;
        if (mismatches == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // no cycle limit here: only the watchdog ends a hung bus wait
    task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp; s_axi_bready <= 1'b0;
    endtask
    task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 1'b0;
    endtask
    // core answer lands in the phase-3 slot of the cycle after a real instruction
    task issue(input logic [2:0] k, input logic [11:0] t);
        logic [11:0] a, e;
        int n;
        n = 0;
        do begin @(posedge core_clk); #1; n++; end while (!(exec_last_phase && exec_valid) && n < 40);
        repeat (4) @(posedge core_clk);
        xfer_kind <= k; xfer_target <= t;
        #1 a = exec_addr;
        @(posedge core_clk);
        xfer_kind <= XF_NONE;
        #1 chk(exec_valid, 1'b0);
        e = a + 12'h002;
        case (k)
            XF_PCL: e = {e[11:8], t[7:0]};
            XF_RET, XF_RETI: e = ret_e;
            XF_JUMP, XF_CALL: e = t;
            default: ;
        endcase
        if (k == XF_CALL) ret_e = a + 12'h001;
        @(posedge core_clk);
        #1 chk(pm_addr, e);
        repeat (3) @(posedge core_clk);
        #1 chk(exec_addr, e);
        chk(exec_instr, {4'ha, e});
    endtask
    task take(input logic [11:0] v);
        int n;
        n = 0;
        do begin last = pm_addr; @(posedge core_clk); #1; n++; end while (pm_addr !== v && n < 60);
        ret_e = last;
        chk(pm_addr, v);
    endtask
    initial begin
        #2000000;
        mismatches++;
        summarize;
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            // control, status, mask, then one unmapped word
            axr((i == 3) ? 8'h10 : 8'(i * 4 + ((i > 0) ? 4 : 0)), rd, rs);
            chk(rd, (i == 3) ? 32'h0 : 32'h0);
            chk(rs, (i == 3) ? RESP_SLVERR : RESP_OKAY);
        end
        axw(8'h14, 32'h1, rs);
        chk(rs, RESP_SLVERR);
        for (int i = 0; i < 7; i++) issue(rows[i][14:12], rows[i][11:0]);
        axw(8'h0c, 32'h3f, rs);
        for (int i = 0; i < 7; i++) begin
            axw(8'h00, (i == 0) ? 32'h3 : 32'h1, rs);
            @(posedge core_clk);
            {ev2_ovf_req, twi_req, uart_req, ev1_ovf_req, ev0_ovf_req, adc_done_req} <= 6'(1 << i);
            ext_int_pin_n <= (i != 6);
            @(posedge core_clk);
            {ev2_ovf_req, twi_req, uart_req, ev1_ovf_req, ev0_ovf_req, adc_done_req} <= 6'h00;
            take(12'(4 * (i % 6 + 1)));
            @(posedge core_clk);
            ext_int_pin_n <= 1'b1;
            axr(8'h08, rd, rs);
            chk(rd, 32'h0);
            issue(XF_RETI, 12'h000);
        end
        @(posedge core_clk);
        {ev1_ovf_req, ev0_ovf_req} <= 2'h3;
        @(posedge core_clk);
        {ev1_ovf_req, ev0_ovf_req} <= 2'h0;
        take(VEC_EV0);
        axr(8'h08, rd, rs);
        chk(rd, 32'h4);
        chk(irq, 1'b1);
        issue(XF_RETI, 12'h000);
        take(VEC_EV1);
        issue(XF_RETI, 12'h000);
        for (int i = 0; i < 8; i++) issue(XF_CALL, 12'h200);
        chk(stack_full, 1'b1);
        @(posedge core_clk);
        ev2_ovf_req <= 1'b1;
        @(posedge core_clk);
        ev2_ovf_req <= 1'b0;
        repeat (12) @(posedge core_clk);
        chk(pm_addr === VEC_EV2, 1'b0);
        issue(XF_RET, 12'h000);
        take(VEC_EV2);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        #1 chk({pm_addr, irq, stack_full}, 14'h0);
        repeat (4) @(posedge core_clk);
        #1 chk({exec_valid, exec_addr}, 13'h1000);
        summarize;
    end
endmodule
bind psv_sequencer psv_checker u_chk (.*);
`default_nettype wire
